// ===== pcd_map.vh
// pcd_map.vh : register offsets, field positions and reset values of the
// pin change detector.
// assumes: included by bare name from the design files, definitions only.
`ifndef PCD_MAP_VH
`define PCD_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------
`define PCD_OFF_RISE_A   8'h00
`define PCD_OFF_FALL_A   8'h04
`define PCD_OFF_FLAG_A   8'h08
`define PCD_OFF_RISE_B   8'h0C
`define PCD_OFF_FALL_B   8'h10
`define PCD_OFF_FLAG_B   8'h14
`define PCD_OFF_RISE_C   8'h18
`define PCD_OFF_FALL_C   8'h1C
`define PCD_OFF_FLAG_C   8'h20
`define PCD_OFF_RISE_E   8'h24
`define PCD_OFF_FALL_E   8'h28
`define PCD_OFF_FLAG_E   8'h2C
`define PCD_OFF_IRQ_EN   8'h30
`define PCD_OFF_IRQ_REQ  8'h34

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PCD_PORT_W       8
`define PCD_BIT_MASTER   0
`define PCD_BIT_SUMMARY  0
`define PCD_PIN_E3       27

// implemented pins in the flat 32-bit vector: ports a, b, c and e bit 3
`define PCD_IMPL_MASK    32'h08FF_FFFF

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PCD_RST_EDGE     32'h0000_0000
`define PCD_RST_FLAG     32'h0000_0000
`define PCD_RST_EN       1'b0
`define PCD_RST_RDATA    32'h0000_0000
`define PCD_PRIME_DONE   2'h3

`endif

// ===== pcd_edge_detect.v
// pcd_edge_detect.v : synchroniser and edge detector for one pin.
// assumes: pin_in is asynchronous to clk; pulses are one clk cycle wide.
`timescale 1ns/1ns
`default_nettype none
`include "pcd_map.vh"

module pcd_edge_detect (
  input  wire clk,
  input  wire rst_n,
  input  wire pin_in,
  output wire rise_pulse,
  output wire fall_pulse
);

  reg       sync1_r;
  reg       sync2_r;
  reg       prev_r;
  reg [1:0] prime_r;
  wire      primed;

  // ----------------------------------------------------------------------
  // two-flop synchroniser, then one more flop for the previous sample
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // comparing is held off until the pipe holds real samples, so a pin
  // that is high at reset does not fake a rising edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prime_r <= 2'h0;
    end else if (prime_r != `PCD_PRIME_DONE) begin
      prime_r <= prime_r + 2'h1;
    end
  end

  assign primed     = (prime_r == `PCD_PRIME_DONE);
  assign rise_pulse = primed & sync2_r & ~prev_r;
  assign fall_pulse = primed & ~sync2_r & prev_r;

endmodule // pcd_edge_detect
`default_nettype wire

// ===== pcd_pin_change_top.v
// pcd_pin_change_top.v : pin change detector with apb register access.
// holds the edge enables, the per-pin change flags, the master enable,
// the summary flag, the interrupt and the sleep wake request.
// assumes: apb master on clk; pins are asynchronous and are synchronised
// here; clk keeps running while the core sleeps.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "pcd_map.vh"

// How it works
// - pins of ports a, b, c and port e bit 3 each detect changes individually.
// - every eligible pin has a separate rising and falling edge detector.
// - a set rise enable bit arms rising detection; clear means rising ignored.
// - a set fall enable bit arms falling detection; clear means falling ignored.
// - both enables set detects either direction on the pin.
// - an armed edge sets the pin flag, which stays until software clears it.
// - master enable clear still detects and flags, but raises no interrupt.
// - interrupt is high only while master enable set and some flag set.
// - summary flag is the or of all pin flags, read only.
// - writing zero to a flag bit clears it, unless applies.
// - an edge in the cycle of a flag write keeps the flag set.
// - eight-bit rise, fall and flag registers per port, bit n is pin n, reset zero.
// - an armed edge during sleep wakes the device when master enable set.
// - a sleep edge updates the flag before the first instruction after wake.
module pcd_pin_change_top (
  input  wire        clk,
  input  wire        rst_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // port pins
  input  wire [7:0]  pin_a,
  input  wire [7:0]  pin_b,
  input  wire [7:0]  pin_c,
  input  wire        port_e_bit3,
  // core state and interrupt
  input  wire        sleep_mode,
  output wire        change_irq,
  output wire        wake_req
);

  // ----------------------------------------------------------------------
  // local codes for the decoded register kind
  // ----------------------------------------------------------------------
  localparam [2:0] KIND_RISE = 3'd0;
  localparam [2:0] KIND_FALL = 3'd1;
  localparam [2:0] KIND_FLAG = 3'd2;
  localparam [2:0] KIND_EN   = 3'd3;
  localparam [2:0] KIND_REQ  = 3'd4;
  localparam [2:0] KIND_NONE = 3'd7;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg  [31:0] rise_edge_enable_r;
  reg  [31:0] rise_edge_enable_nxt;
  reg  [31:0] fall_edge_enable_r;
  reg  [31:0] fall_edge_enable_nxt;
  reg  [31:0] pin_change_flag_r;
  reg  [31:0] pin_change_flag_nxt;
  reg         change_irq_master_enable_r;
  reg         change_irq_master_enable_nxt;
  reg         irq_r;
  reg  [31:0] prdata_r;
  reg  [31:0] prdata_nxt;
  reg         pslverr_r;
  reg  [2:0]  sel_kind;
  reg  [1:0]  sel_port;
  reg  [31:0] wr_clr;
  reg  [31:0] wr_byte;

  wire [31:0] pin_vec;
  wire [31:0] rise_pulse;
  wire [31:0] fall_pulse;
  wire [31:0] edge_set;
  wire        setup_phase;
  wire        wr_access;
  wire        wr_low_lane;
  wire        change_summary_flag;

  // ----------------------------------------------------------------------
  // pin gathering: byte 0 port a, 1 port b, 2 port c, 3 port e (bit 3)
  // ----------------------------------------------------------------------
  assign pin_vec = {4'h0, port_e_bit3, 3'h0, pin_c, pin_b, pin_a};

  // ----------------------------------------------------------------------
  // per-pin edge detection; unimplemented positions never pulse
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_pin
      if (((`PCD_IMPL_MASK >> g) & 1) == 1) begin : g_live
        pcd_edge_detect u_edge (
          .clk        (clk),
          .rst_n      (rst_n),
          .pin_in     (pin_vec[g]),
          .rise_pulse (rise_pulse[g]),
          .fall_pulse (fall_pulse[g])
        );
      end else begin : g_dead
        assign rise_pulse[g] = 1'b0;
        assign fall_pulse[g] = 1'b0;
      end
    end
  endgenerate

  // an edge counts only in the direction that is armed; with both bits
  // set either direction sets the flag
  assign edge_set = ((rise_pulse & rise_edge_enable_r)
                   | (fall_pulse & fall_edge_enable_r))
                   & `PCD_IMPL_MASK;

  // ----------------------------------------------------------------------
  // apb address decode
  // ----------------------------------------------------------------------
  always @* begin
    sel_kind = KIND_NONE;
    sel_port = 2'd0;
    case (paddr)
      `PCD_OFF_RISE_A: begin
        sel_kind = KIND_RISE;
        sel_port = 2'd0;
      end
      `PCD_OFF_FALL_A: begin
        sel_kind = KIND_FALL;
        sel_port = 2'd0;
      end
      `PCD_OFF_FLAG_A: begin
        sel_kind = KIND_FLAG;
        sel_port = 2'd0;
      end
      `PCD_OFF_RISE_B: begin
        sel_kind = KIND_RISE;
        sel_port = 2'd1;
      end
      `PCD_OFF_FALL_B: begin
        sel_kind = KIND_FALL;
        sel_port = 2'd1;
      end
      `PCD_OFF_FLAG_B: begin
        sel_kind = KIND_FLAG;
        sel_port = 2'd1;
      end
      `PCD_OFF_RISE_C: begin
        sel_kind = KIND_RISE;
        sel_port = 2'd2;
      end
      `PCD_OFF_FALL_C: begin
        sel_kind = KIND_FALL;
        sel_port = 2'd2;
      end
      `PCD_OFF_FLAG_C: begin
        sel_kind = KIND_FLAG;
        sel_port = 2'd2;
      end
      `PCD_OFF_RISE_E: begin
        sel_kind = KIND_RISE;
        sel_port = 2'd3;
      end
      `PCD_OFF_FALL_E: begin
        sel_kind = KIND_FALL;
        sel_port = 2'd3;
      end
      `PCD_OFF_FLAG_E: begin
        sel_kind = KIND_FLAG;
        sel_port = 2'd3;
      end
      `PCD_OFF_IRQ_EN: begin
        sel_kind = KIND_EN;
      end
      `PCD_OFF_IRQ_REQ: begin
        sel_kind = KIND_REQ;
      end
      default: begin
        sel_kind = KIND_NONE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // apb phases: no wait states, writes land at the access edge
  // ----------------------------------------------------------------------
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite & (sel_kind != KIND_NONE);
  assign wr_low_lane = wr_access & pstrb[0];   // registers live in lane 0

  // write data placed in the selected port byte, for the edge enables
  always @* begin
    wr_byte = 32'h0000_0000;
    wr_byte[sel_port*`PCD_PORT_W +: `PCD_PORT_W] = pwdata[7:0];
  end

  // flag bits written as zero in the selected port byte
  always @* begin
    wr_clr = 32'h0000_0000;
    if (wr_low_lane && (sel_kind == KIND_FLAG)) begin
      wr_clr[sel_port*`PCD_PORT_W +: `PCD_PORT_W] = ~pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // edge enable registers
  // ----------------------------------------------------------------------
  always @* begin
    rise_edge_enable_nxt = rise_edge_enable_r;
    fall_edge_enable_nxt = fall_edge_enable_r;
    if (wr_low_lane && (sel_kind == KIND_RISE)) begin
      rise_edge_enable_nxt[sel_port*`PCD_PORT_W +: `PCD_PORT_W] =
        wr_byte[sel_port*`PCD_PORT_W +: `PCD_PORT_W];
    end
    if (wr_low_lane && (sel_kind == KIND_FALL)) begin
      fall_edge_enable_nxt[sel_port*`PCD_PORT_W +: `PCD_PORT_W] =
        wr_byte[sel_port*`PCD_PORT_W +: `PCD_PORT_W];
    end
    // port e keeps only bit 3; other positions stay zero
    rise_edge_enable_nxt = rise_edge_enable_nxt & `PCD_IMPL_MASK;
    fall_edge_enable_nxt = fall_edge_enable_nxt & `PCD_IMPL_MASK;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_edge_enable_r <= `PCD_RST_EDGE;
      fall_edge_enable_r <= `PCD_RST_EDGE;
    end else begin
      rise_edge_enable_r <= rise_edge_enable_nxt;
      fall_edge_enable_r <= fall_edge_enable_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // pin change flags: sticky, cleared by writing zero
  // ----------------------------------------------------------------------
  // the set term is or-ed in after the clear, so an edge in the write
  // cycle survives; writing a one leaves a flag as it is, which is what
  // makes the and-mask clearing sequence safe
  always @* begin
    pin_change_flag_nxt = ((pin_change_flag_r & ~wr_clr)
                         | edge_set)
                         & `PCD_IMPL_MASK;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_change_flag_r <= `PCD_RST_FLAG;
    end else begin
      pin_change_flag_r <= pin_change_flag_nxt;
    end
  end

  // flags are set even with the master enable clear
  assign change_summary_flag = |pin_change_flag_r;

  // ----------------------------------------------------------------------
  // master enable (enable register, which also acts as the mask)
  // ----------------------------------------------------------------------
  always @* begin
    change_irq_master_enable_nxt = change_irq_master_enable_r;
    if (wr_low_lane && (sel_kind == KIND_EN)) begin
      change_irq_master_enable_nxt = pwdata[`PCD_BIT_MASTER];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      change_irq_master_enable_r <= `PCD_RST_EN;
    end else begin
      change_irq_master_enable_r <= change_irq_master_enable_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt: registered from the next state, so it follows the flags
  // and the enable in the same cycle they change
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= change_irq_master_enable_nxt & (|pin_change_flag_nxt);
    end
  end

  assign change_irq = irq_r;

  // wake only when the interrupt itself is raised; the flag is already
  // stored when wake rises, so the first instruction sees it
  assign wake_req = sleep_mode & irq_r;

  // ----------------------------------------------------------------------
  // read data, captured in the setup phase; a flag set between setup and
  // access shows on the next read
  // ----------------------------------------------------------------------
  always @* begin
    prdata_nxt = 32'h0000_0000;
    case (sel_kind)
      KIND_RISE: begin
        prdata_nxt[7:0] = rise_edge_enable_r[sel_port*`PCD_PORT_W +: `PCD_PORT_W];
      end
      KIND_FALL: begin
        prdata_nxt[7:0] = fall_edge_enable_r[sel_port*`PCD_PORT_W +: `PCD_PORT_W];
      end
      KIND_FLAG: begin
        prdata_nxt[7:0] = pin_change_flag_r[sel_port*`PCD_PORT_W +: `PCD_PORT_W];
      end
      KIND_EN: begin
        prdata_nxt[`PCD_BIT_MASTER] = change_irq_master_enable_r;
      end
      KIND_REQ: begin
        prdata_nxt[`PCD_BIT_SUMMARY] = change_summary_flag;
      end
      default: begin
        prdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r  <= `PCD_RST_RDATA;
      pslverr_r <= 1'b0;
    end else if (setup_phase) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : prdata_nxt;
      pslverr_r <= (sel_kind == KIND_NONE);   // unmapped address
    end
  end

  // ----------------------------------------------------------------------
  // apb answer: always ready, error flagged only in the access phase
  // ----------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel & penable & pslverr_r;
  assign prdata  = prdata_r;

endmodule // pcd_pin_change_top
`default_nettype wire

// ===== pcd_pin_change_checker.sv
// pcd_pin_change_checker.sv : port-level assertions for the pin change detector.
// assumes: bound to pcd_pin_change_top, one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module pcd_pin_change_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  pin_a,
  input wire logic [7:0]  pin_b,
  input wire logic [7:0]  pin_c,
  input wire logic        port_e_bit3,
  input wire logic        sleep_mode,
  input wire logic        change_irq,
  input wire logic        wake_req
);
  // ----------------------------------------------------------------------
  // helper decode
  // ----------------------------------------------------------------------
  wire [24:0] pins   = {port_e_bit3, pin_c, pin_b, pin_a};
  wire        acc    = psel & penable;
  wire        wr_acc = acc & pwrite;
  wire        rd_acc = acc & ~pwrite;
  wire        unmap  = (paddr > 8'h34) | (paddr[1:0] != 2'h0);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // the interrupt only rises from a pin change three edges back or a register write
  AST_IRQ_RISE: assert property ($rose(change_irq) |->
    $past(pins, 3) != $past(pins, 4) || $past(wr_acc) || $past(wr_acc, 2))
    else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(change_irq) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("interrupt fell without a write");
  AST_WAKE: assert property (wake_req == (sleep_mode && change_irq))
    else $error("wake request wrong");
  AST_ERR_PHASE: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  AST_ERR_UNMAP: assert property (acc && unmap |-> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_MAP: assert property (acc && !unmap |-> !pslverr)
    else $error("mapped access refused");
  AST_RD_UNMAP: assert property (rd_acc && unmap |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_RD_BYTE: assert property (rd_acc |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_RD_PORTE: assert property (rd_acc && paddr >= 8'h24 && paddr <= 8'h2C |->
    prdata[7:4] == 4'h0 && prdata[2:0] == 3'h0) else $error("port e spare bit set");
  AST_RD_ONE: assert property (rd_acc && paddr >= 8'h30 |-> prdata[31:1] == 31'h0)
    else $error("control read spare bits set");
  AST_PREADY: assert property (pready)
    else $error("ready dropped");

  // main scenarios reached
  COV_IRQ: cover property ($rose(change_irq));
  COV_ERR: cover property (pslverr);
  COV_WAKE: cover property (wake_req);
endmodule // pcd_pin_change_checker

bind pcd_pin_change_top pcd_pin_change_checker i_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_a(pin_a), .pin_b(pin_b),
  .pin_c(pin_c), .port_e_bit3(port_e_bit3), .sleep_mode(sleep_mode),
  .change_irq(change_irq), .wake_req(wake_req));
`default_nettype wire

// ===== pcd_pin_model.sv
// pcd_pin_model.sv : external signals on the port pins.
// assumes: bench asks for a new level set right after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module pcd_pin_model (
  input  wire logic        clk,
  input  wire logic [31:0] level,
  output var  logic [7:0]  pin_a,
  output var  logic [7:0]  pin_b,
  output var  logic [7:0]  pin_c,
  output var  logic        port_e_bit3
);
  // one process drives the pins; they are unknown only until the first edge, inside reset
  // levels move one edge after the request and then hold, so each change lasts a clock or more
  always @(posedge clk) begin
    pin_a       <= level[7:0];
    pin_b       <= level[15:8];
    pin_c       <= level[23:16];
    port_e_bit3 <= level[27];
  end
endmodule // pcd_pin_model
`default_nettype wire

// ===== pin_change_interrupt_bench.sv
// pin_change_interrupt_bench.sv : self-checking bench for the pin change detector.
// assumes: pcd_pin_change_top, the pin model and the bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
`include "pcd_map.vh"
module pin_change_interrupt_bench;
  logic        clk, rst_n, psel, penable, pwrite, sleep_mode, err, master_m;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, level, rd, rise_m, fall_m, flag_m, pins_m;
  logic [31:0] seed = 32'h0000_0006;
  wire  [31:0] prdata;
  wire  [7:0]  pin_a, pin_b, pin_c;
  wire         pready, pslverr, port_e_bit3, change_irq, wake_req;
  int          err_count = 0;
  int          n_compared = 0;

  pcd_pin_change_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c),
    .port_e_bit3(port_e_bit3), .sleep_mode(sleep_mode), .change_irq(change_irq),
    .wake_req(wake_req));
  pcd_pin_model i_pins (.clk(clk), .level(level), .pin_a(pin_a), .pin_b(pin_b),
    .pin_c(pin_c), .port_e_bit3(port_e_bit3));

  // ----------------------------------------------------------------------
  // helpers, model and bus tasks
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t level %b expected %b", $time, got, exp);
    end
  endtask

  // one apb transfer, entered right after an edge; idles one cycle after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) begin
      err_count++;
      $display("[FAIL] %0t no ready on transfer", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // expected register contents from the integer model
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    int s;
    s = 8 * (a / 12);
    if (a == 8'h30) return {31'h0, master_m};
    if (a == 8'h34) return {31'h0, |flag_m};
    if (a > 8'h34) return 32'h0000_0000;
    if (a % 12 == 0) return (rise_m >> s) & 32'h0000_00FF;
    if (a % 12 == 4) return (fall_m >> s) & 32'h0000_00FF;
    return (flag_m >> s) & 32'h0000_00FF;
  endfunction

  // model of a register write; flags only clear where a zero is written
  task automatic mwr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] m;
    m = (32'h0000_00FF << (8 * (a / 12))) & `PCD_IMPL_MASK;
    if (a == 8'h30) master_m = d[0];
    d = d << (8 * (a / 12));
    if (a < 8'h30 && a % 12 == 0) rise_m = (rise_m & ~m) | (d & m);
    if (a < 8'h30 && a % 12 == 4) fall_m = (fall_m & ~m) | (d & m);
    if (a < 8'h30 && a % 12 == 8) flag_m = flag_m & (d | ~m);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    mwr(a, d);
  endtask

  // model of armed edges on a new pin level set
  task automatic mpins(input logic [31:0] nw);
    nw = nw & `PCD_IMPL_MASK;
    flag_m = flag_m | (nw & ~pins_m & rise_m) | (~nw & pins_m & fall_m);
    pins_m = nw;
  endtask

  task automatic drive(input logic [31:0] nw);
    level <= nw;
    mpins(nw);
    repeat (5) @(posedge clk);
  endtask

  task automatic test_done;
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #1_000_000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] a;
    {rst_n, psel, penable, pwrite, sleep_mode, master_m} = 6'h00;
    {paddr, pwdata, level, rise_m, fall_m, flag_m, pins_m} = 200'h0;
    pstrb = 4'hF;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // reset values, plus two unmapped words at the end
    for (int i = 0; i < 16; i++) begin
      a = 8'(4 * i);
      apb(1'b0, a, 32'h0000_0000);
      chk_val(rd, exp_rd(a));
      chk_bit(err, a > 8'h34);
    end
    // random enables, pins, writes (read-only and master included) and reads
    for (int i = 0; i < 60; i++) begin
      sleep_mode <= (i >= 40);
      wreg(8'(4 * (xs() % 14)), xs());
      drive(xs());
      chk_bit(change_irq, master_m & |flag_m);
      chk_bit(wake_req, sleep_mode & master_m & |flag_m);
      a = 8'(4 * (xs() % 14));
      apb(1'b0, a, 32'h0000_0000);
      chk_val(rd, exp_rd(a));
      a = 8'(12 * (xs() % 4) + 8);
      apb(1'b0, a, 32'h0000_0000);
      wreg(a, ~rd);
    end
    // a clearing write lands on the edge that sets the flag
    wreg(8'h00, 32'h0000_00FF);
    wreg(8'h04, 32'h0000_0000);
    drive(32'h0000_0000);
    wreg(8'h08, 32'h0000_0000);
    level <= 32'h0000_0001;
    mwr(8'h08, 32'h0000_0000);
    mpins(32'h0000_0001);
    repeat (2) @(posedge clk);
    apb(1'b1, 8'h08, 32'h0000_0000);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk_val(rd, exp_rd(8'h08));
    // a write with lane 0 off must leave the enable as it was
    pstrb <= 4'h0;
    apb(1'b1, 8'h00, 32'h0000_0000);
    pstrb <= 4'hF;
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk_val(rd, exp_rd(8'h00));
    // mid-run reset with pin a0 high, armed at once: no false rising edge
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    {rise_m, fall_m, flag_m, master_m} = 97'h0;
    wreg(8'h00, 32'h0000_00FF);
    repeat (4) @(posedge clk);
    chk_bit(change_irq, 1'b0);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk_val(rd, exp_rd(8'h08));
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk_val(rd, exp_rd(8'h04));
    test_done;
  end
endmodule // pin_change_interrupt_bench
`default_nettype wire
